// ===== logic/atatf_pkg.sv
`default_nettype none
package atatf_pkg;
    // ------------------------------------------------------------
    // Register addresses {block, da[2:0]}; block 1 = command, 0 = control
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_DATA      = 4'h8;
    localparam logic [3:0] ADDR_ERR_FEAT  = 4'h9;
    localparam logic [3:0] ADDR_SECT_CNT  = 4'hA;
    localparam logic [3:0] ADDR_SECT_NUM  = 4'hB;
    localparam logic [3:0] ADDR_CYL_LOW   = 4'hC;
    localparam logic [3:0] ADDR_CYL_HIGH  = 4'hD;
    localparam logic [3:0] ADDR_DEV_HEAD  = 4'hE;
    localparam logic [3:0] ADDR_STAT_CMD  = 4'hF;
    localparam logic [3:0] ADDR_ALT_CTRL  = 4'h6;
    localparam logic [3:0] ADDR_DRV_ADDR  = 4'h7;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_SRST  = 2;
    localparam int CTRL_NIEN  = 1;
    localparam int DH_LBA     = 6;
    localparam int DH_DEV     = 4;
    localparam int ST_BSY     = 7;
    localparam int ST_DRDY    = 6;
    localparam int ST_DF      = 5;
    localparam int ST_DSC     = 4;
    localparam int ST_DRQ     = 3;
    localparam int ST_IDX     = 1;
    localparam int ST_ERR     = 0;
    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SECT_CNT   = 8'h01;
    localparam logic [7:0] RST_SECT_NUM   = 8'h01;
    localparam logic [7:0] RST_CYL        = 8'h00;
    localparam logic [7:0] RST_DEV_HEAD   = 8'hA0;
    localparam logic [7:0] DH_FIXED_ONES  = 8'hA0;
    localparam logic [7:0] ERR_MASK       = 8'hD7;
    localparam logic [7:0] DIAG_NO_ERROR  = 8'h01;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int SRST_MIN_NS     = 5000;
    localparam int SRST_MIN_CYCLES = (SRST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage
`default_nettype wire

// ===== logic/atatf_regs.sv
// Notes on behaviour
// R1: Cylinder high holds cylinder upper byte or LBA 23:16; reloaded at command end.
// R2: Cylinder low holds cylinder lower byte or LBA 15:8; reloaded at command end.
// R3: Data port is 16 bits wide, 8 bits for ECC bytes, PIO only.
// R4: Data port reads are meaningful only while DRQ is set.
// R5: Control bit 2 holds the device in soft reset; host keeps it 5 us.
// R6: Control bit 1 low enables interrupts, only while this device is selected.
// R7: Drive address: bit 7 undriven, bit 6 low writing, inverted head, low selects.
// R8: Device/head bit 6 picks CHS or LBA; bits 7 and 5 read as one.
// R9: Device/head bit 4 picks device 0 or device 1.
// R10: Device/head bits 3:0 hold head or LBA 27:24; reloaded at completion.
// R11: Error bits: CRC, uncorrectable, ID not found, abort, track 0, mark; 5,3 zero.
// R12: Error holds diagnostic code after reset or diagnostic, else error status.
// R13: Sector count gives sectors to move; zero means 256.
// R14: At completion sector count is zero on success, else sectors remaining.
// R15: Sector number holds start sector or LBA 7:0; reloaded at command end.
// R16: Reading status acknowledges and clears the pending interrupt.
// R17: While busy every register read returns status; host stays away.
// R18: DRDY low at power-up until ready, and from an error until status read.
// R19: Device fault sets on write fault and clears on status read.
// R20: Seek complete clears before seek, sets when settled, holds after error, set standby.
// R21: Status bit 4 is service after queued DMA commands, else seek complete.
// R22: ERR sets on errored command end, clears when next command arrives.
// R23: Alternate status mirrors status without acknowledging the interrupt.
// R24: Command write starts execution at once; parameters loaded beforehand.
`timescale 1ns/100ps
`default_nettype none
module atatf_regs #(
    parameter bit DEVICE_ID   = 1'b0,
    parameter int SRST_CYCLES = atatf_pkg::SRST_MIN_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // Host pins
    input  wire logic        i_cs0_n,
    input  wire logic        i_cs1_n,
    input  wire logic [2:0]  i_da,
    input  wire logic        i_dior_n,
    input  wire logic        i_diow_n,
    input  wire logic [15:0] i_dd,
    output logic      [15:0] o_dd,
    output logic      [15:0] o_dd_oe,
    output logic             o_intrq,
    // Device core side
    output logic             o_cmd_strobe,
    output logic      [7:0]  o_cmd_code,
    output logic      [7:0]  o_features,
    output logic      [7:0]  o_sect_cnt,
    output logic      [8:0]  o_sect_total,
    output logic      [7:0]  o_sect_num,
    output logic      [7:0]  o_cyl_low,
    output logic      [7:0]  o_cyl_high,
    output logic      [7:0]  o_dev_head,
    output logic             o_soft_reset,
    output logic             o_data_wr,
    output logic      [15:0] o_data_wr_word,
    output logic             o_data_rd,
    input  wire logic        i_byte_mode,
    input  wire logic [15:0] i_data_rd_word,
    input  wire logic        i_busy,
    input  wire logic        i_ready,
    input  wire logic        i_drq,
    input  wire logic        i_index,
    input  wire logic        i_seek_done,
    input  wire logic        i_seek_start,
    input  wire logic        i_standby,
    input  wire logic        i_write_fault,
    input  wire logic        i_service,
    input  wire logic        i_queued_mode,
    input  wire logic        i_writing,
    input  wire logic        i_done,
    input  wire logic        i_done_err,
    input  wire logic [7:0]  i_done_err_bits,
    input  wire logic [7:0]  i_done_sect_cnt,
    input  wire logic [7:0]  i_done_sect_num,
    input  wire logic [7:0]  i_done_cyl_low,
    input  wire logic [7:0]  i_done_cyl_high,
    input  wire logic [3:0]  i_done_head,
    input  wire logic        i_diag_done,
    input  wire logic [7:0]  i_diag_code,
    input  wire logic        i_irq_event
);
    if (SRST_CYCLES < 1) begin : g_srst_check
        $error("SRST_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------
    // Pin synchronisers and strobe edges
    // ------------------------------------------------------------
    logic [6:0] pins_s;
    logic [15:0] dd_s;
    logic        rd_s_q;
    logic        wr_s_q;

    atatf_sync2 #(.WIDTH(7)) u_sync_ctl (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async ({i_cs0_n, i_cs1_n, i_da, i_dior_n, i_diow_n}),
        .o_sync  (pins_s)
    );
    atatf_sync2 #(.WIDTH(16)) u_sync_dat (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_async (i_dd),
        .o_sync  (dd_s)
    );

    wire       cs0_s  = ~pins_s[6];
    wire       cs1_s  = ~pins_s[5];
    wire [2:0] da_s   = pins_s[4:2];
    wire       rd_s   = ~pins_s[1];
    wire       wr_s   = ~pins_s[0];
    wire       valid  = cs0_s ^ cs1_s;
    wire [3:0] addr   = {cs0_s, da_s};
    wire       rd_end = rd_s_q & ~rd_s & valid;
    wire       wr_end = wr_s_q & ~wr_s & valid;
    wire       reading = rd_s & valid;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] sect_cnt_q;
    logic [7:0] sect_num_q;
    logic [7:0] cyl_low_q;
    logic [7:0] cyl_high_q;
    logic [7:0] dev_head_q;
    logic [7:0] features_q;
    logic [7:0] cmd_q;
    logic [7:0] error_q;
    logic       nien_q;
    logic       srst_q;
    logic       drdy_err_q;
    logic       df_q;
    logic       dsc_q;
    logic       err_q;
    logic       irq_q;
    logic       cmd_stb_q;
    logic       data_wr_q;
    logic [15:0] data_wr_word_q;
    logic       data_rd_q;
    logic [15:0] dd_q;
    logic       dd_oe_q;

    wire wr_cmd_blk = wr_end & cs0_s;
    wire selected   = (dev_head_q[atatf_pkg::DH_DEV] == DEVICE_ID);                 // R9
    wire rd_status  = rd_end & selected & (addr == atatf_pkg::ADDR_STAT_CMD);       // R16
    wire accept_wr  = wr_end & ~i_busy;                                             // R17
    wire soft_rst   = srst_q;

    // ------------------------------------------------------------
    // Status assembly
    // ------------------------------------------------------------
    wire bit4 = i_queued_mode ? i_service : dsc_q;                                  // R21
    wire [7:0] status_w = {i_busy,
                           i_ready & ~drdy_err_q,                                   // R18
                           df_q,
                           bit4,
                           i_drq,
                           1'b0,
                           i_index,
                           err_q};
    wire [7:0] drv_addr_w = {1'b0,
                             ~i_writing,                                            // R7
                             ~dev_head_q[3:0],
                             ~(selected & DEVICE_ID),
                             ~(selected & ~DEVICE_ID)};
    wire [15:0] data_out  = i_drq ? (i_byte_mode ? {8'h00, i_data_rd_word[7:0]}    // R3
                                                 : i_data_rd_word)
                                  : 16'h0000;                                       // R4

    logic [15:0] rd_mux;
    always_comb begin
        unique case (addr)
            atatf_pkg::ADDR_DATA:     rd_mux = data_out;
            atatf_pkg::ADDR_ERR_FEAT: rd_mux = {8'h00, error_q};
            atatf_pkg::ADDR_SECT_CNT: rd_mux = {8'h00, sect_cnt_q};
            atatf_pkg::ADDR_SECT_NUM: rd_mux = {8'h00, sect_num_q};
            atatf_pkg::ADDR_CYL_LOW:  rd_mux = {8'h00, cyl_low_q};
            atatf_pkg::ADDR_CYL_HIGH: rd_mux = {8'h00, cyl_high_q};
            atatf_pkg::ADDR_DEV_HEAD: rd_mux = {8'h00, dev_head_q};
            atatf_pkg::ADDR_STAT_CMD: rd_mux = {8'h00, status_w};
            atatf_pkg::ADDR_ALT_CTRL: rd_mux = {8'h00, status_w};                   // R23
            atatf_pkg::ADDR_DRV_ADDR: rd_mux = {8'h00, drv_addr_w};
            default:                  rd_mux = 16'h0000;
        endcase
    end
    wire [15:0] rd_value = i_busy ? {8'h00, status_w} : rd_mux;                     // R17
    wire drives = reading & selected & (addr != 4'h0) & (addr[3] | addr[2]) &
                  ((addr[3] | addr[1]));
    wire [15:0] oe_mask = (addr == atatf_pkg::ADDR_DATA && !i_busy) ? 16'hFFFF :
                          (addr == atatf_pkg::ADDR_DRV_ADDR) ? 16'h007F : 16'h00FF;  // R7

    // ------------------------------------------------------------
    // Host writes and completion loads
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sect_cnt_q <= atatf_pkg::RST_SECT_CNT;
            sect_num_q <= atatf_pkg::RST_SECT_NUM;
            cyl_low_q  <= atatf_pkg::RST_CYL;
            cyl_high_q <= atatf_pkg::RST_CYL;
            dev_head_q <= atatf_pkg::RST_DEV_HEAD;
            features_q <= 8'h00;
            cmd_q      <= 8'h00;
        end else if (soft_rst) begin
            sect_cnt_q <= atatf_pkg::RST_SECT_CNT;
            sect_num_q <= atatf_pkg::RST_SECT_NUM;
            cyl_low_q  <= atatf_pkg::RST_CYL;
            cyl_high_q <= atatf_pkg::RST_CYL;
            dev_head_q <= atatf_pkg::RST_DEV_HEAD;
        end else if (i_done) begin
            sect_cnt_q <= i_done_err ? i_done_sect_cnt : 8'h00;                     // R14
            sect_num_q <= i_done_sect_num;                                          // R15
            cyl_low_q  <= i_done_cyl_low;                                           // R2
            cyl_high_q <= i_done_cyl_high;                                          // R1
            dev_head_q <= {dev_head_q[7:4], i_done_head};                           // R10
        end else if (accept_wr && cs0_s) begin
            unique case (da_s)
                3'd1: features_q <= dd_s[7:0];
                3'd2: sect_cnt_q <= dd_s[7:0];                                      // R13
                3'd3: sect_num_q <= dd_s[7:0];                                      // R15
                3'd4: cyl_low_q  <= dd_s[7:0];                                      // R2
                3'd5: cyl_high_q <= dd_s[7:0];                                      // R1
                3'd6: dev_head_q <= dd_s[7:0] | atatf_pkg::DH_FIXED_ONES;           // R8
                3'd7: cmd_q      <= dd_s[7:0];                                      // R24
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control register and soft reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            nien_q <= 1'b0;
            srst_q <= 1'b0;
        end else if (wr_end && cs1_s && da_s == atatf_pkg::ADDR_ALT_CTRL[2:0]) begin
            nien_q <= dd_s[atatf_pkg::CTRL_NIEN];                                   // R6
            srst_q <= dd_s[atatf_pkg::CTRL_SRST];                                   // R5
        end
    end

    // ------------------------------------------------------------
    // Status flags, error register and interrupt
    // ------------------------------------------------------------
    wire cmd_write = accept_wr & cs0_s & (da_s == 3'd7) & selected;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            drdy_err_q <= 1'b0;
            df_q       <= 1'b0;
            dsc_q      <= 1'b1;
            err_q      <= 1'b0;
            irq_q      <= 1'b0;
            error_q    <= atatf_pkg::DIAG_NO_ERROR;
            cmd_stb_q  <= 1'b0;
        end else if (soft_rst) begin
            drdy_err_q <= 1'b0;
            df_q       <= 1'b0;
            dsc_q      <= 1'b1;
            err_q      <= 1'b0;
            irq_q      <= 1'b0;
            error_q    <= atatf_pkg::DIAG_NO_ERROR;                                 // R12
            cmd_stb_q  <= 1'b0;
        end else begin
            cmd_stb_q  <= cmd_write;                                                // R24
            drdy_err_q <= (i_done & i_done_err) | (drdy_err_q & ~rd_status);        // R18
            df_q       <= i_write_fault | (df_q & ~rd_status);                      // R19
            if (i_standby || (i_seek_done && !drdy_err_q)) begin
                dsc_q <= 1'b1;                                                      // R20
            end else if (i_seek_start && !drdy_err_q) begin
                dsc_q <= 1'b0;                                                      // R20
            end
            if (i_done) begin
                err_q <= i_done_err;                                                // R22
            end else if (cmd_write) begin
                err_q <= 1'b0;                                                      // R22
            end
            if (i_diag_done) begin
                error_q <= i_diag_code;                                             // R12
            end else if (i_done) begin
                error_q <= i_done_err_bits & atatf_pkg::ERR_MASK;                   // R11
            end
            irq_q <= i_irq_event | (irq_q & ~rd_status);                            // R16
        end
    end

    // ------------------------------------------------------------
    // Data port strobes and read drive
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rd_s_q         <= 1'b0;
            wr_s_q         <= 1'b0;
            data_wr_q      <= 1'b0;
            data_wr_word_q <= 16'h0000;
            data_rd_q      <= 1'b0;
            dd_q           <= 16'h0000;
            dd_oe_q        <= 1'b0;
        end else begin
            rd_s_q    <= rd_s;
            wr_s_q    <= wr_s;
            data_wr_q <= accept_wr & i_drq & (addr == atatf_pkg::ADDR_DATA);        // R4
            data_rd_q <= rd_end & ~i_busy & i_drq & (addr == atatf_pkg::ADDR_DATA); // R4
            if (accept_wr && addr == atatf_pkg::ADDR_DATA) begin
                data_wr_word_q <= i_byte_mode ? {8'h00, dd_s[7:0]} : dd_s;          // R3
            end
            dd_q    <= rd_value;
            dd_oe_q <= drives & ~soft_rst;
        end
    end

    assign o_dd           = dd_q;
    assign o_dd_oe        = dd_oe_q ? oe_mask : 16'h0000;
    assign o_intrq        = irq_q & ~nien_q & selected;                             // R6
    assign o_cmd_strobe   = cmd_stb_q;
    assign o_cmd_code     = cmd_q;
    assign o_features     = features_q;
    assign o_sect_cnt     = sect_cnt_q;
    assign o_sect_total   = (sect_cnt_q == 8'h00) ? 9'd256 : {1'b0, sect_cnt_q};   // R13
    assign o_sect_num     = sect_num_q;
    assign o_cyl_low      = cyl_low_q;
    assign o_cyl_high     = cyl_high_q;
    assign o_dev_head     = dev_head_q;
    assign o_soft_reset   = srst_q;                                                 // R5
    assign o_data_wr      = data_wr_q;
    assign o_data_wr_word = data_wr_word_q;
    assign o_data_rd      = data_rd_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_status_ack_irq: assert property (@(posedge i_clock) disable iff (!i_rstn) // R16
        rd_status && !soft_rst && !i_irq_event |=> !irq_q)
        else $error("interrupt not cleared by status read");
    a_alt_keeps_irq: assert property (@(posedge i_clock) disable iff (!i_rstn) // R23
        rd_end && addr == atatf_pkg::ADDR_ALT_CTRL && irq_q && !soft_rst |=> irq_q)
        else $error("alternate status read cleared interrupt");
    a_intrq_gate: assert property (@(posedge i_clock) disable iff (!i_rstn) // R6
        o_intrq |-> !nien_q && selected)
        else $error("interrupt driven while disabled");
    a_busy_status: assert property (@(posedge i_clock) disable iff (!i_rstn) // R17
        i_busy |-> rd_value == {8'h00, status_w})
        else $error("busy read returned non-status");
    a_df_clear: assert property (@(posedge i_clock) disable iff (!i_rstn) // R19
        df_q && rd_status && !i_write_fault |=> !df_q)
        else $error("fault not cleared on status read");
    a_count_done: assert property (@(posedge i_clock) disable iff (!i_rstn) // R14
        i_done && !i_done_err && !soft_rst |=> sect_cnt_q == 8'h00)
        else $error("sector count not zero after success");
    a_err_next_cmd: assert property (@(posedge i_clock) disable iff (!i_rstn) // R22
        cmd_write && !i_done && !soft_rst |=> !err_q)
        else $error("ERR not cleared by new command");
    a_dh_fixed: assert property (@(posedge i_clock) disable iff (!i_rstn) // R8
        dev_head_q[7] && dev_head_q[5])
        else $error("device/head fixed bits not one");
    a_err_zero_bits: assert property (@(posedge i_clock) disable iff (!i_rstn) // R11
        $rose(i_done) && !i_diag_done && !soft_rst |=> error_q[5] == 1'b0 && error_q[3] == 1'b0)
        else $error("error reserved bits set");
    a_drdy_err: assert property (@(posedge i_clock) disable iff (!i_rstn) // R18
        i_done && i_done_err && !soft_rst |=> !status_w[atatf_pkg::ST_DRDY])
        else $error("DRDY not dropped on error");
endmodule
`default_nettype wire

// ===== logic/atatf_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module atatf_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== test/atatf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module atatf_host_model (
    input  wire logic        i_clock,
    input  wire logic [15:0] i_dd,
    input  wire logic [15:0] i_dd_oe,
    output logic             o_cs0_n,
    output logic             o_cs1_n,
    output logic      [2:0]  o_da,
    output logic             o_dior_n,
    output logic             o_diow_n,
    output logic      [15:0] o_dd
);
    initial begin
        {o_cs0_n, o_cs1_n, o_dior_n, o_diow_n} = 4'hf;
        o_da = 3'h0;
        o_dd = 16'h0000;
    end
    // Strobe low 6 clocks, then 8 quiet clocks; parameters precede commands
    task automatic acc(input logic [3:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
        @(posedge i_clock);
        #1;
        {o_cs0_n, o_cs1_n, o_da, o_dd} = {~a[3], a[3], a[2:0], d};
        if (w) o_diow_n = 1'b0;
        else o_dior_n = 1'b0;
        repeat (6) @(posedge i_clock);
        #1;
        r = i_dd & i_dd_oe;
        {o_dior_n, o_diow_n} = 2'b11;
        repeat (2) @(posedge i_clock);
        #1;
        {o_cs0_n, o_cs1_n, o_dd} = {2'b11, ~d};
        repeat (6) @(posedge i_clock);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== test/test_ata_task_file_registers.sv
`timescale 1ns/100ps
`default_nettype none
module test_ata_task_file_registers;
    logic        i_clock, i_rstn, i_cs0_n, i_cs1_n, i_dior_n, i_diow_n, o_intrq, o_cmd_strobe, o_soft_reset;
    logic        o_data_wr, o_data_rd, i_byte_mode, i_busy, i_ready, i_drq, i_index, i_seek_done, i_seek_start;
    logic        i_standby, i_write_fault, i_service, i_queued_mode, i_writing, i_done, i_done_err, i_diag_done;
    logic        i_irq_event;
    logic [2:0]  i_da;
    logic [3:0]  i_done_head;
    logic [8:0]  o_sect_total;
    logic [15:0] i_dd, o_dd, o_dd_oe, i_data_rd_word, o_data_wr_word, rd;
    logic [7:0]  o_cmd_code, o_features, o_sect_cnt, o_sect_num, o_cyl_low, o_cyl_high, o_dev_head, i_diag_code;
    logic [7:0]  i_done_err_bits, i_done_sect_cnt, i_done_sect_num, i_done_cyl_low, i_done_cyl_high;
    int          error_cnt, comparisons, cycles, pulses;
    atatf_regs dut_u (.*);
    atatf_host_model host_u (.i_clock(i_clock), .i_dd(o_dd), .i_dd_oe(o_dd_oe), .o_cs0_n(i_cs0_n),
        .o_cs1_n(i_cs1_n), .o_da(i_da), .o_dior_n(i_dior_n), .o_diow_n(i_diow_n), .o_dd(i_dd));
    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        pulses += o_cmd_strobe + o_data_wr + o_data_rd;
        if (cycles == 8000) begin
            error_cnt++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge i_clock);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        host_u.acc(a, 1'b1, d, rd);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        host_u.acc(a, 1'b0, 16'h0000, rd);
        chk(rd, e);
    endtask
    task automatic irq_pulse;
        step;
        i_irq_event = 1'b1;
        step;
        i_irq_event = 1'b0;
        repeat (3) step;
    endtask
    task automatic t_reset;
        rdc(atatf_pkg::ADDR_SECT_CNT, 16'h0001);
        rdc(atatf_pkg::ADDR_DEV_HEAD, 16'h00a0);
        rdc(atatf_pkg::ADDR_ERR_FEAT, 16'h0001);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0050);
    endtask
    task automatic t_regs;
        wr(atatf_pkg::ADDR_CYL_HIGH, 16'h005a);
        wr(atatf_pkg::ADDR_CYL_LOW, 16'h00a5);
        wr(atatf_pkg::ADDR_SECT_NUM, 16'h003c);
        wr(atatf_pkg::ADDR_DEV_HEAD, 16'h004f);
        wr(atatf_pkg::ADDR_SECT_CNT, 16'h0000);
        rdc(atatf_pkg::ADDR_CYL_HIGH, 16'h005a);
        rdc(atatf_pkg::ADDR_CYL_LOW, 16'h00a5);
        rdc(atatf_pkg::ADDR_SECT_NUM, 16'h003c);
        rdc(atatf_pkg::ADDR_DEV_HEAD, 16'h00ef);
        rdc(atatf_pkg::ADDR_DRV_ADDR, 16'h0042);
        chk({7'h00, o_sect_total}, 16'h0100);
    endtask
    task automatic t_done;
        step;
        {i_done, i_done_err, i_done_err_bits, i_done_sect_cnt, i_done_head} = {2'b11, 8'hff, 8'h07, 4'h3};
        step;
        {i_done, i_done_err} = 2'b00;
        rdc(atatf_pkg::ADDR_SECT_CNT, 16'h0007);
        rdc(atatf_pkg::ADDR_DEV_HEAD, 16'h00e3);
        rdc(atatf_pkg::ADDR_CYL_HIGH, 16'h0000);
        rdc(atatf_pkg::ADDR_ERR_FEAT, 16'h00d7);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0011);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0051);
        wr(atatf_pkg::ADDR_STAT_CMD, 16'h0020);
        chk(o_cmd_code, 16'h0020);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0050);
    endtask
    task automatic t_irq;
        irq_pulse;
        chk(o_intrq, 16'h0001);
        rdc(atatf_pkg::ADDR_ALT_CTRL, 16'h0050);
        chk(o_intrq, 16'h0001);
        wr(atatf_pkg::ADDR_DEV_HEAD, 16'h0053);
        chk(o_intrq, 16'h0000);
        rdc(atatf_pkg::ADDR_CYL_HIGH, 16'h0000);
        wr(atatf_pkg::ADDR_DEV_HEAD, 16'h0043);
        chk(o_intrq, 16'h0001);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0050);
        chk(o_intrq, 16'h0000);
        wr(atatf_pkg::ADDR_ALT_CTRL, 16'h000a);
        irq_pulse;
        chk(o_intrq, 16'h0000);
        wr(atatf_pkg::ADDR_ALT_CTRL, 16'h0008);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0050);
    endtask
    task automatic t_busy;
        step;
        {i_drq, i_data_rd_word} = {1'b1, 16'hbeef};
        rdc(atatf_pkg::ADDR_DATA, 16'hbeef);
        wr(atatf_pkg::ADDR_DATA, 16'h1234);
        chk(o_data_wr_word, 16'h1234);
        i_byte_mode = 1'b1;
        rdc(atatf_pkg::ADDR_DATA, 16'h00ef);
        i_byte_mode = 1'b0;
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0058);
        i_busy = 1'b1;
        rdc(atatf_pkg::ADDR_SECT_NUM, 16'h00d8);
        {i_busy, i_drq} = 2'b00;
        rdc(atatf_pkg::ADDR_DATA, 16'h0000);
    endtask
    task automatic t_flags;
        chk(pulses[15:0], 16'h0004);
        {i_write_fault, i_queued_mode, i_index, i_writing, i_seek_start} = 5'b11111;
        step;
        {i_write_fault, i_seek_start} = 2'b00;
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0062);
        i_queued_mode = 1'b0;
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0042);
        i_standby = 1'b1;
        rdc(atatf_pkg::ADDR_DRV_ADDR, 16'h0032);
        rdc(atatf_pkg::ADDR_STAT_CMD, 16'h0052);
        {i_index, i_writing, i_standby} = 3'b000;
    endtask
    task automatic t_srst;
        wr(atatf_pkg::ADDR_ALT_CTRL, 16'h000c);
        chk(o_soft_reset, 16'h0001);
        repeat (atatf_pkg::SRST_MIN_CYCLES) step;
        wr(atatf_pkg::ADDR_ALT_CTRL, 16'h0008);
        chk(o_soft_reset, 16'h0000);
        rdc(atatf_pkg::ADDR_SECT_CNT, 16'h0001);
    endtask
    initial begin
        {i_rstn, i_byte_mode, i_busy, i_drq, i_index, i_seek_done, i_seek_start, i_standby, i_write_fault} = '0;
        {i_service, i_queued_mode, i_writing, i_done, i_done_err, i_diag_done, i_irq_event, i_diag_code} = '0;
        {i_data_rd_word, i_done_head, i_done_err_bits, i_done_sect_cnt, i_done_sect_num} = '0;
        {i_done_cyl_low, i_done_cyl_high, error_cnt, comparisons, cycles, pulses} = '0;
        i_ready = 1'b1;
        repeat (12) step;
        i_rstn = 1'b1;
        repeat (3) step;
        t_reset;
        t_regs;
        t_done;
        t_irq;
        t_busy;
        t_flags;
        t_srst;
        give_verdict;
    end
endmodule
`default_nettype wire
